// ===== hdl/fpgs_supervisor.sv
// Supervisor: over-voltage latch, over-temperature trip, power-good and AXI4-Lite registers
//
// Contract
// - After over-voltage fault, switches stay off until bias or enable cycles.
// - Output OV warning, UV warning and UV fault compare telemetry with limits.
// - Effective over-temperature trip is the lower of fixed and programmed limits.
// - Fixed over-temperature indication stops switching; clearing it restarts automatically.
// - Programmed temperature limit in whole degrees; trip when reading exceeds it.
// - Programmed trip response: keep converting (default) or latched shutdown.
// - Latched over-temperature clears only by enable or operation off-on cycling.
// - Reset values: programmed limit 150 degrees, response ignore.
// - With policy bit set, upper power-good threshold programmable in 1/256 V.
// - Programmed level rounds to 85, 90 or 95 percent by ranges; the code also gives 80 percent below the 85 range.
// - Default threshold 90 percent; power-good asserts when feedback exceeds it.
// - Power-good drops when feedback falls below threshold minus 5 percent.
// - Power-good needs enable, bias, no OC, OV or OT fault, feedback above.
// - Policy bit 1 (reset value): same threshold rule at start-up and after.
// - Policy bit 0: first assertion needs feedback within 2 percent of target.
// - OV fault after comparator stays high past filter; switches off, power-good low.
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module fpgs_supervisor
  import fpgs_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire fpgs_axi_req_t axiReq,
  output fpgs_axi_rsp_t axiRsp,
  input wire fpgs_sense_t sense,
  output fpgs_flags_t flags
);

  fpgs_sup_state_t st_r;
  fpgs_sup_state_t st_nxt;

  logic ovpFire;
  logic ovpClear;
  logic [6:0] pgPct;
  logic runOk;
  logic progTrip;
  logic ovWarnNow;
  logic pgBase;
  logic [31:0] fbScaled;
  logic [31:0] upperLvl;
  logic [31:0] lowerLvl;
  logic [31:0] winLo;
  logic [31:0] winHi;
  logic fbAboveUpper;
  logic fbBelowLower;
  logic fbInWindow;

  // Bias or enable loss is what releases the over-voltage latch
  assign ovpClear = !sense.enable || !sense.biasGood;

  fpgs_persist_filter #(
    .LIMIT(OVP_DELAY_CYC),
    .CNT_W(OVP_CNT_W)
  ) u_ovp_filter (
    .core_clk(core_clk),
    .nrst(nrst),
    .level(sense.fbOverOvp),
    .clear(ovpClear),
    .fire(ovpFire)
  );

  fpgs_pg_quant u_pg_quant (
    .voutSet(st_r.cfg.voutSet),
    .pgOn(st_r.cfg.pgOn),
    .pgPct(pgPct)
  );

  assign runOk = sense.enable && sense.biasGood && st_r.cfg.opOn;
  // The programmed limit only acts while it sits below the fixed one
  assign progTrip = (sense.tempTelem > st_r.cfg.otLimit) && (st_r.cfg.otLimit < OT_FIXED_C);
  assign ovWarnNow = sense.voutTelem > st_r.cfg.ovWarnLim;

  assign fbScaled = 32'(sense.fbSense) * 32'(PCT_FULL);
  assign upperLvl = 32'(st_r.cfg.voutSet) * 32'(pgPct);
  assign lowerLvl = 32'(st_r.cfg.voutSet) * 32'(7'(pgPct - PG_HYST));
  assign winLo = 32'(st_r.cfg.voutSet) * 32'(7'(PCT_FULL - PG_WIN));
  assign winHi = 32'(st_r.cfg.voutSet) * 32'(7'(PCT_FULL + PG_WIN));
  assign fbAboveUpper = fbScaled > upperLvl;
  assign fbBelowLower = fbScaled < lowerLvl;
  assign fbInWindow = (fbScaled >= winLo) && (fbScaled <= winHi);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  always_comb begin
    st_nxt = st_r;
    pgBase = 1'b0;

    // Write address and data are taken independently, in either order
    if (axiReq.awvalid && st_r.rsp.awready) begin
      st_nxt.awGot = 1'b1;
      st_nxt.awAddr = axiReq.awaddr;
      st_nxt.rsp.awready = 1'b0;
    end
    if (axiReq.wvalid && st_r.rsp.wready) begin
      st_nxt.wGot = 1'b1;
      st_nxt.wData = axiReq.wdata;
      st_nxt.wStrb = axiReq.wstrb;
      st_nxt.rsp.wready = 1'b0;
    end
    if (st_r.awGot && st_r.wGot && !st_r.rsp.bvalid) begin
      st_nxt.awGot = 1'b0;
      st_nxt.wGot = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = AXI_OKAY;
      if (st_r.awAddr == REG_CTRL) begin
        if (st_r.wStrb[0]) begin
          st_nxt.cfg.opOn = st_r.wData[CTRL_OP_ON_BIT];
          st_nxt.cfg.pgPolicy = st_r.wData[CTRL_PG_POLICY_BIT];
          st_nxt.cfg.otLatchResp = st_r.wData[CTRL_OT_LATCH_BIT];
        end
      end else if (st_r.awAddr == REG_VOUT_SET) begin
        st_nxt.cfg.voutSet = merge16(st_r.cfg.voutSet, st_r.wData, st_r.wStrb);
      end else if (st_r.awAddr == REG_PG_ON) begin
        st_nxt.cfg.pgOn = merge16(st_r.cfg.pgOn, st_r.wData, st_r.wStrb);
      end else if (st_r.awAddr == REG_OV_WARN) begin
        st_nxt.cfg.ovWarnLim = merge16(st_r.cfg.ovWarnLim, st_r.wData, st_r.wStrb);
      end else if (st_r.awAddr == REG_UV_WARN) begin
        st_nxt.cfg.uvWarnLim = merge16(st_r.cfg.uvWarnLim, st_r.wData, st_r.wStrb);
      end else if (st_r.awAddr == REG_UV_FAULT) begin
        st_nxt.cfg.uvFaultLim = merge16(st_r.cfg.uvFaultLim, st_r.wData, st_r.wStrb);
      end else if (st_r.awAddr == REG_OT_LIMIT) begin
        st_nxt.cfg.otLimit = merge16(st_r.cfg.otLimit, st_r.wData, st_r.wStrb);
      end else if (st_r.awAddr == REG_STATUS) begin
        st_nxt.rsp.bresp = AXI_OKAY;
      end else begin
        st_nxt.rsp.bresp = AXI_SLVERR;
      end
    end
    if (st_r.rsp.bvalid && axiReq.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
      st_nxt.rsp.awready = 1'b1;
      st_nxt.rsp.wready = 1'b1;
    end

    // Reads answer on the same edge that takes the address
    if (axiReq.arvalid && st_r.rsp.arready) begin
      st_nxt.rsp.arready = 1'b0;
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp = AXI_OKAY;
      if (axiReq.araddr == REG_CTRL) begin
        st_nxt.rsp.rdata = 32'({st_r.cfg.otLatchResp, st_r.cfg.pgPolicy, st_r.cfg.opOn});
      end else if (axiReq.araddr == REG_VOUT_SET) begin
        st_nxt.rsp.rdata = 32'(st_r.cfg.voutSet);
      end else if (axiReq.araddr == REG_PG_ON) begin
        st_nxt.rsp.rdata = 32'(st_r.cfg.pgOn);
      end else if (axiReq.araddr == REG_OV_WARN) begin
        st_nxt.rsp.rdata = 32'(st_r.cfg.ovWarnLim);
      end else if (axiReq.araddr == REG_UV_WARN) begin
        st_nxt.rsp.rdata = 32'(st_r.cfg.uvWarnLim);
      end else if (axiReq.araddr == REG_UV_FAULT) begin
        st_nxt.rsp.rdata = 32'(st_r.cfg.uvFaultLim);
      end else if (axiReq.araddr == REG_OT_LIMIT) begin
        st_nxt.rsp.rdata = 32'(st_r.cfg.otLimit);
      end else if (axiReq.araddr == REG_STATUS) begin
        st_nxt.rsp.rdata = 32'(st_r.flags);
      end else begin
        st_nxt.rsp.rdata = '0;
        st_nxt.rsp.rresp = AXI_SLVERR;
      end
    end
    if (st_r.rsp.rvalid && axiReq.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
      st_nxt.rsp.arready = 1'b1;
    end

    // Over-voltage latch; only bias or enable loss releases it
    if (ovpClear) begin
      st_nxt.flags.ovpLatched = 1'b0;
    end else if (ovpFire) begin
      st_nxt.flags.ovpLatched = 1'b1;
    end

    // Latched over-temperature, cleared while enable or operation is off
    if (!sense.enable || !st_r.cfg.opOn) begin
      st_nxt.flags.otLatched = 1'b0;
    end else if (progTrip && st_r.cfg.otLatchResp) begin
      st_nxt.flags.otLatched = 1'b1;
    end
    st_nxt.flags.progOtTrip = progTrip;

    // Fixed trip gates switching directly, so restart needs no software
    st_nxt.flags.switchesOff = st_nxt.flags.ovpLatched || st_nxt.flags.otLatched ||
                               sense.otFixedTrip || !runOk;

    st_nxt.flags.ovWarn = ovWarnNow;
    st_nxt.flags.uvWarn = sense.voutTelem < st_r.cfg.uvWarnLim;
    st_nxt.flags.uvFault = sense.voutTelem < st_r.cfg.uvFaultLim;

    pgBase = runOk && !sense.ocFault && !st_nxt.flags.ovpLatched && !sense.otFixedTrip &&
             !st_nxt.flags.otLatched;

    case (st_r.pgState)
      PG_STARTUP: begin
        if (pgBase && (st_r.cfg.pgPolicy ? fbAboveUpper : fbInWindow)) begin
          st_nxt.pgState = PG_GOOD;
        end
      end
      PG_GOOD: begin
        if (!pgBase) begin
          st_nxt.pgState = PG_STARTUP;
        end else if (fbBelowLower) begin
          st_nxt.pgState = PG_LOST;
        end
      end
      PG_LOST: begin
        if (!pgBase) begin
          st_nxt.pgState = PG_STARTUP;
        end else if (fbAboveUpper) begin
          st_nxt.pgState = PG_GOOD;
        end
      end
      default: begin
        st_nxt.pgState = PG_STARTUP;
      end
    endcase
    st_nxt.flags.powerGood = st_nxt.pgState == PG_GOOD;
    st_nxt.flags.pgDriveLow = st_nxt.pgState != PG_GOOD;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.cfg <= CFG_RST;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready <= 1'b1;
      st_r.rsp.arready <= 1'b1;
      st_r.pgState <= PG_STARTUP;
      st_r.flags.switchesOff <= 1'b1;
      st_r.flags.pgDriveLow <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axiRsp = st_r.rsp;
  assign flags = st_r.flags;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  a_ovp_latch_hold: assert property (
    flags.ovpLatched && sense.enable && sense.biasGood |=> flags.ovpLatched)
    else $error("over-voltage latch released without a cycle");
  a_ovp_forces_off: assert property (
    ovpFire && !ovpClear |=> flags.ovpLatched && flags.switchesOff && !flags.powerGood)
    else $error("over-voltage fault did not stop switching");
  a_ovp_latch_off: assert property (
    flags.ovpLatched |-> flags.switchesOff && !flags.powerGood)
    else $error("switching while the over-voltage latch is set");
  // At the release edge the flags still hold reset values, so only attempts begun out of reset count
  a_ov_warn_cmp: assert property (
    nrst |=> flags.ovWarn == ($past(sense.voutTelem) > $past(st_r.cfg.ovWarnLim)))
    else $error("over-voltage warning disagrees with telemetry");
  a_uv_warn_cmp: assert property (
    nrst |=> flags.uvWarn == ($past(sense.voutTelem) < $past(st_r.cfg.uvWarnLim)))
    else $error("under-voltage warning disagrees with telemetry");
  a_uv_fault_cmp: assert property (
    nrst |=> flags.uvFault == ($past(sense.voutTelem) < $past(st_r.cfg.uvFaultLim)))
    else $error("under-voltage fault disagrees with telemetry");
  a_ot_fixed_stop: assert property (
    sense.otFixedTrip |=> flags.switchesOff && !flags.powerGood)
    else $error("fixed over-temperature did not stop switching");
  a_ot_auto_restart: assert property (
    runOk && !sense.otFixedTrip && !flags.ovpLatched && !ovpFire && !flags.otLatched && !progTrip
    |=> !flags.switchesOff)
    else $error("switching did not restart");
  a_ot_latch_set: assert property (
    progTrip && st_r.cfg.otLatchResp && sense.enable && st_r.cfg.opOn |=> flags.otLatched)
    else $error("programmed trip did not latch");
  a_ot_ignore_resp: assert property (
    !st_r.cfg.otLatchResp && !flags.otLatched |=> !flags.otLatched)
    else $error("ignore response latched a shutdown");
  a_ot_latch_hold: assert property (
    flags.otLatched && sense.enable && st_r.cfg.opOn |=> flags.otLatched)
    else $error("over-temperature latch released without a cycle");
  a_ot_latch_off: assert property (
    flags.otLatched |-> flags.switchesOff)
    else $error("switching while the over-temperature latch is set");
  a_ot_prog_trip: assert property (
    sense.tempTelem > st_r.cfg.otLimit && st_r.cfg.otLimit < OT_FIXED_C |=> flags.progOtTrip)
    else $error("programmed over-temperature limit did not trip");
  a_ot_prog_quiet: assert property (
    sense.tempTelem <= st_r.cfg.otLimit |=> !flags.progOtTrip)
    else $error("programmed over-temperature tripped at or below its limit");
  a_pg_hyst_drop: assert property (
    flags.powerGood && fbBelowLower |=> !flags.powerGood)
    else $error("power-good held below the lower threshold");
  a_pg_needs_base: assert property (
    !pgBase |=> !flags.powerGood && flags.pgDriveLow)
    else $error("power-good asserted without its conditions");
  a_pg_upper_start: assert property (
    st_r.pgState == PG_STARTUP && st_r.cfg.pgPolicy && !fbAboveUpper |=> !flags.powerGood)
    else $error("power-good rose below the upper threshold");
  a_pg_window_start: assert property (
    st_r.pgState == PG_STARTUP && !st_r.cfg.pgPolicy && !fbInWindow |=> !flags.powerGood)
    else $error("power-good rose outside the start-up window");
  a_pg_low_pin: assert property (
    flags.pgDriveLow != flags.powerGood)
    else $error("power-good pin enable disagrees with power-good");

endmodule

// ===== hdl/fpgs_pkg.sv
// Shared constants, register map and carrier types of the fault and power-good supervisor
package fpgs_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OVP_DELAY_NS = 5000;
  localparam int OVP_DELAY_CYC = (OVP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVP_CNT_W = 10;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VOUT_SET = 8'h04;
  localparam logic [7:0] REG_PG_ON = 8'h08;
  localparam logic [7:0] REG_OV_WARN = 8'h0C;
  localparam logic [7:0] REG_UV_WARN = 8'h10;
  localparam logic [7:0] REG_UV_FAULT = 8'h14;
  localparam logic [7:0] REG_OT_LIMIT = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  // Control register fields
  localparam int CTRL_OP_ON_BIT = 0;
  localparam int CTRL_PG_POLICY_BIT = 1;
  localparam int CTRL_OT_LATCH_BIT = 2;

  // Reset values, voltages in 1/256 V, temperatures in whole degrees
  localparam logic [15:0] VOUT_SET_RST = 16'h009A;
  localparam logic [15:0] PG_ON_RST = 16'h008A;
  localparam logic [15:0] OV_WARN_RST = 16'h00AA;
  localparam logic [15:0] UV_WARN_RST = 16'h0080;
  localparam logic [15:0] UV_FAULT_RST = 16'h0073;
  localparam logic [15:0] OT_LIMIT_RST = 16'h0096;
  localparam logic [15:0] OT_FIXED_C = 16'h0091;

  // Power-good quantisation, bounds in units of 0.01 percent
  localparam logic [31:0] PG_SCALE = 32'h0000_2710;
  localparam logic [31:0] PG_B_85 = 32'h0000_1F18;
  localparam logic [31:0] PG_B_90 = 32'h0000_213E;
  localparam logic [31:0] PG_B_95 = 32'h0000_2315;
  localparam logic [6:0] PCT_80 = 7'h50;
  localparam logic [6:0] PCT_85 = 7'h55;
  localparam logic [6:0] PCT_90 = 7'h5A;
  localparam logic [6:0] PCT_95 = 7'h5F;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PG_HYST = 7'h05;
  localparam logic [6:0] PG_WIN = 7'h02;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } fpgs_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fpgs_axi_rsp_t;

  typedef struct packed {
    logic enable;
    logic biasGood;
    logic fbOverOvp;
    logic otFixedTrip;
    logic ocFault;
    logic [15:0] voutTelem;
    logic [15:0] tempTelem;
    logic [15:0] fbSense;
  } fpgs_sense_t;

  typedef struct packed {
    logic uvFault;
    logic uvWarn;
    logic ovWarn;
    logic progOtTrip;
    logic otLatched;
    logic ovpLatched;
    logic pgDriveLow;
    logic powerGood;
    logic switchesOff;
  } fpgs_flags_t;

  typedef struct packed {
    logic otLatchResp;
    logic pgPolicy;
    logic opOn;
    logic [15:0] voutSet;
    logic [15:0] pgOn;
    logic [15:0] ovWarnLim;
    logic [15:0] uvWarnLim;
    logic [15:0] uvFaultLim;
    logic [15:0] otLimit;
  } fpgs_cfg_t;

  localparam fpgs_cfg_t CFG_RST = '{otLatchResp: 1'b0, pgPolicy: 1'b1, opOn: 1'b1,
    voutSet: VOUT_SET_RST, pgOn: PG_ON_RST, ovWarnLim: OV_WARN_RST, uvWarnLim: UV_WARN_RST,
    uvFaultLim: UV_FAULT_RST, otLimit: OT_LIMIT_RST};

  typedef enum logic [1:0] {PG_STARTUP, PG_GOOD, PG_LOST} fpgs_pg_state_t;

  typedef struct packed {
    fpgs_cfg_t cfg;
    fpgs_axi_rsp_t rsp;
    logic awGot;
    logic wGot;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    fpgs_pg_state_t pgState;
    fpgs_flags_t flags;
  } fpgs_sup_state_t;

endpackage

// ===== hdl/fpgs_persist_filter.sv
// Persistence filter: fires once a level has stayed high longer than a cycle limit
`timescale 1ns/100ps
module fpgs_persist_filter
  import fpgs_pkg::*;
#(
  parameter int unsigned LIMIT = OVP_DELAY_CYC,
  parameter int unsigned CNT_W = OVP_CNT_W
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic level,
  input wire logic clear,
  output logic fire
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic fire;
  } fpgs_filt_state_t;

  fpgs_filt_state_t st_r;
  fpgs_filt_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // Any dip restarts the count, so glitches never accumulate
    if (clear || !level) begin
      st_nxt.cnt = '0;
      st_nxt.fire = 1'b0;
    end else if (st_r.cnt == CNT_W'(LIMIT)) begin
      st_nxt.fire = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fire = st_r.fire;

  a_filter_fires: assert property (@(posedge core_clk) disable iff (!nrst)
    level && !clear && st_r.cnt == CNT_W'(LIMIT) |=> fire)
    else $error("filter did not fire after the limit");
  a_filter_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    !level |=> !fire && st_r.cnt == '0)
    else $error("filter fired without a high level");

endmodule

// ===== hdl/fpgs_pg_quant.sv
// Rounds the programmed power-good level to one of four percentages of the setpoint
`timescale 1ns/100ps
module fpgs_pg_quant
  import fpgs_pkg::*;
(
  input wire logic [15:0] voutSet,
  input wire logic [15:0] pgOn,
  output logic [6:0] pgPct
);

  logic [31:0] progScaled;

  // Ratio is compared by cross-multiplying, which avoids a divider
  always_comb begin
    progScaled = 32'(pgOn) * PG_SCALE;
    if (progScaled > 32'(voutSet) * PG_B_95) begin
      pgPct = PCT_95;
    end else if (progScaled > 32'(voutSet) * PG_B_90) begin
      pgPct = PCT_90;
    end else if (progScaled > 32'(voutSet) * PG_B_85) begin
      pgPct = PCT_85;
    end else begin
      pgPct = PCT_80;
    end
  end

endmodule

// ===== verification/fpgs_sense_model.sv
// Far-side model: comparators and telemetry converters feeding the supervisor
`timescale 1ns/100ps
module fpgs_sense_model
  import fpgs_pkg::*;
#(
  parameter logic [15:0] OVP_LEVEL = 16'h0133
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic enablePin,
  input wire logic biasOk,
  input wire logic overCurrent,
  input wire logic [15:0] fbLevel,
  input wire logic [15:0] dieTemp,
  input wire logic [15:0] voutLevel,
  output fpgs_sense_t sense
);
  // One cycle of converter latency, so the bench never sees a same-edge path
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sense <= '0;
    end else begin
      sense.enable <= enablePin;
      sense.biasGood <= biasOk;
      sense.fbOverOvp <= fbLevel > OVP_LEVEL;
      sense.otFixedTrip <= dieTemp > OT_FIXED_C;
      sense.ocFault <= overCurrent;
      sense.voutTelem <= voutLevel;
      sense.tempTelem <= dieTemp;
      sense.fbSense <= fbLevel;
    end
  end
endmodule

// ===== verification/fpgs_supervisor_tb.sv
// Self-checking bench of the fault and power-good supervisor
`timescale 1ns/100ps
module fpgs_supervisor_tb
  import fpgs_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  fpgs_axi_req_t axiReq = '0;
  fpgs_axi_rsp_t axiRsp;
  fpgs_sense_t sense;
  fpgs_flags_t flags;
  logic enablePin = 1'b1;
  logic biasOk = 1'b1;
  logic overCurrent = 1'b0;
  logic [15:0] fbLevel = 16'h0000;
  logic [15:0] dieTemp = 16'h0019;
  logic [15:0] voutLevel = 16'h009A;
  int errCount = 0;
  int checks = 0;
  int cycles = 0;
  logic [1:0] resp;
  logic [15:0] vTab [6] = '{16'h00AB, 16'h00AA, 16'h0080, 16'h007F, 16'h0073, 16'h0072};
  logic [2:0] wTab [6] = '{3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h6};
  // Setpoint 0x100: 80/85/90/95 percent thresholds sit at 204.8/217.6/230.4/243.2
  logic [15:0] pgTab [4] = '{16'h00C8, 16'h00CC, 16'h00DB, 16'h00F0};
  logic [15:0] fbTab [4] = '{16'h00CD, 16'h00DA, 16'h00E7, 16'h00F4};

  fpgs_supervisor dut_u (.core_clk(core_clk), .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp),
    .sense(sense), .flags(flags));
  fpgs_sense_model far_u (.core_clk(core_clk), .nrst(nrst), .enablePin(enablePin), .biasOk(biasOk),
    .overCurrent(overCurrent), .fbLevel(fbLevel), .dieTemp(dieTemp), .voutLevel(voutLevel), .sense(sense));

  always #5 core_clk = ~core_clk;

  task automatic test_done();
    if (errCount == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errCount++;
      test_done();
    end
  end

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!axiRsp.bvalid);
    axiReq.bready <= 1'b0;
    resp = axiRsp.bresp;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid);
    axiReq.rready <= 1'b0;
    ck(axiRsp.rdata, exp);
    ck({30'h0, axiRsp.rresp}, {30'h0, er});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic pgk(input logic e);
    ck({30'h0, flags.pgDriveLow, flags.powerGood}, {30'h0, ~e, e});
  endtask

  task automatic otk(input logic [2:0] e);
    ck({29'h0, flags.progOtTrip, flags.otLatched, flags.switchesOff}, {29'h0, e});
  endtask

  task automatic ovk(input logic [1:0] e);
    ck({30'h0, flags.ovpLatched, flags.switchesOff}, {30'h0, e});
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(REG_CTRL, 32'h0000_0003, AXI_OKAY);
    rd(REG_OT_LIMIT, 32'h0000_0096, AXI_OKAY);
    rd(REG_PG_ON, 32'h0000_008A, AXI_OKAY);
    rd(8'h20, 32'h0000_0000, AXI_SLVERR);
    wr(8'h24, 32'h0000_0001);
    ck({30'h0, resp}, {30'h0, AXI_SLVERR});
    @(posedge core_clk) fbLevel <= 16'h008A;
    settle(3);
    pgk(1'b0);
    @(posedge core_clk) fbLevel <= 16'h008B;
    settle(3);
    pgk(1'b1);
    @(posedge core_clk) fbLevel <= 16'h0083;
    settle(3);
    pgk(1'b1);
    @(posedge core_clk) fbLevel <= 16'h0082;
    settle(3);
    pgk(1'b0);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk) voutLevel <= vTab[i];
      settle(3);
      ck({29'h0, flags.uvFault, flags.uvWarn, flags.ovWarn}, {29'h0, wTab[i]});
    end
    wr(REG_VOUT_SET, 32'h0000_0100);
    for (int i = 0; i < 4; i++) begin
      wr(REG_PG_ON, {16'h0, pgTab[i]});
      @(posedge core_clk) fbLevel <= fbTab[i] - 16'h0001;
      settle(3);
      pgk(1'b0);
      @(posedge core_clk) fbLevel <= fbTab[i];
      settle(3);
      pgk(1'b1);
      @(posedge core_clk) fbLevel <= 16'h0000;
      settle(3);
      pgk(1'b0);
    end
    @(posedge core_clk) fbLevel <= 16'h00F4;
    settle(3);
    pgk(1'b1);
    @(posedge core_clk) overCurrent <= 1'b1;
    settle(3);
    pgk(1'b0);
    @(posedge core_clk) overCurrent <= 1'b0;
    settle(3);
    pgk(1'b1);
    @(posedge core_clk) biasOk <= 1'b0;
    settle(3);
    pgk(1'b0);
    ovk(2'h1);
    @(posedge core_clk) biasOk <= 1'b1;
    // Start-up again with the window policy: above upper but outside 2 percent
    wr(REG_CTRL, 32'h0000_0001);
    @(posedge core_clk) enablePin <= 1'b0;
    settle(3);
    @(posedge core_clk) fbLevel <= 16'h0106;
    @(posedge core_clk) enablePin <= 1'b1;
    settle(3);
    pgk(1'b0);
    @(posedge core_clk) fbLevel <= 16'h0100;
    settle(3);
    pgk(1'b1);
    @(posedge core_clk) fbLevel <= 16'h00F0;
    settle(3);
    pgk(1'b1);
    wr(REG_CTRL, 32'h0000_0003);
    @(posedge core_clk) dieTemp <= 16'h0092;
    settle(3);
    otk(3'h1);
    pgk(1'b0);
    @(posedge core_clk) dieTemp <= 16'h0091;
    settle(3);
    otk(3'h0);
    wr(REG_OT_LIMIT, 32'h0000_0064);
    @(posedge core_clk) dieTemp <= 16'h0065;
    settle(3);
    otk(3'h4);
    @(posedge core_clk) dieTemp <= 16'h0064;
    settle(3);
    otk(3'h0);
    wr(REG_CTRL, 32'h0000_0007);
    @(posedge core_clk) dieTemp <= 16'h0065;
    settle(3);
    otk(3'h7);
    @(posedge core_clk) dieTemp <= 16'h0019;
    settle(3);
    otk(3'h3);
    wr(REG_CTRL, 32'h0000_0006);
    wr(REG_CTRL, 32'h0000_0007);
    settle(3);
    otk(3'h0);
    // Filter must restart on a short dip, so 400 + 480 high cycles never latch early
    @(posedge core_clk) fbLevel <= 16'h0140;
    settle(400);
    @(posedge core_clk) fbLevel <= 16'h0100;
    settle(2);
    @(posedge core_clk) fbLevel <= 16'h0140;
    settle(480);
    ovk(2'h0);
    settle(40);
    ovk(2'h3);
    pgk(1'b0);
    @(posedge core_clk) fbLevel <= 16'h0100;
    settle(5);
    ovk(2'h3);
    @(posedge core_clk) enablePin <= 1'b0;
    settle(3);
    @(posedge core_clk) enablePin <= 1'b1;
    settle(3);
    ovk(2'h0);
    // Reset again in mid-run: limits, policy and flags return to their reset values
    @(posedge core_clk) nrst <= 1'b0;
    settle(2);
    ck(32'(flags), 32'h0000_0005);
    @(posedge core_clk) nrst <= 1'b1;
    rd(REG_CTRL, 32'h0000_0003, AXI_OKAY);
    rd(REG_OT_LIMIT, 32'h0000_0096, AXI_OKAY);
    rd(REG_VOUT_SET, 32'h0000_009A, AXI_OKAY);
    settle(3);
    rd(REG_STATUS, 32'h0000_0182, AXI_OKAY);
    wr(REG_STATUS, 32'h0000_0000);
    ck({30'h0, resp}, {30'h0, AXI_OKAY});
    rd(REG_STATUS, 32'h0000_0182, AXI_OKAY);
    test_done();
  end
endmodule
